// ===== hdl/fswg_top.sv
// Status register, write-enable gating and busy tracking of a serial flash, behind its SPI pins.
// Assumes SPI mode 0, 4-byte addresses, and an array engine on clk that pulses op_done.
`include "fswg_consts.svh"

module fswg_top
  import fswg_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        sck,
  input  wire logic                        cs_n,
  input  wire logic                        si,
  input  wire logic                        wp_n,
  output logic                             so,
  output logic                             so_oe_n,
  input  wire logic                        op_done,
  output logic                             op_start,
  output fswg_kind_type                    op_kind,
  output logic [`FSWG_ADDR_W-1:0]          op_addr,
  output logic [`FSWG_ADDR_W-1:`FSWG_SECT_LSB]  op_sector,
  output logic [`FSWG_ADDR_W-1:`FSWG_BLK32_LSB] op_blk32,
  output logic [`FSWG_ADDR_W-1:`FSWG_BLK64_LSB] op_blk64,
  output logic                             suspend_req,
  output logic                             quad_enable,
  output logic [7:0]                       status_register
);

  // Pin synchronisers: stage one, stage two, and for sck and cs_n a delayed copy for edges.
  logic [2:0]          sck_s;
  logic [2:0]          cs_s;
  logic [1:0]          si_s;
  logic [1:0]          wp_s;
  logic                busy_flag;
  logic                write_enable_latch;
  logic [3:0]          block_protect;
  logic                status_write_disable;
  fswg_state_type      state;
  fswg_state_type      next_state;
  logic [7:0]          opcode;
  logic [7:0]          in_sr;
  logic [2:0]          bit_cnt;
  logic [2:0]          addr_cnt;
  logic                addr_done;
  logic [31:0]         addr_sr;
  logic [7:0]          wr_data;
  logic                wr_valid;
  logic                rd_active;
  logic [7:0]          out_sr;
  logic [2:0]          out_cnt;
  fswg_kind_type       busy_kind;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_s <= 3'h0;
      cs_s  <= 3'h7;
      si_s  <= 2'h0;
      wp_s  <= 2'h3;
    end else begin
      sck_s <= {sck_s[1:0], sck};
      cs_s  <= {cs_s[1:0], cs_n};
      si_s  <= {si_s[0], si};
      wp_s  <= {wp_s[0], wp_n};
    end
  end

  wire       sel       = ~cs_s[1];
  wire       sck_rise  = sel & sck_s[1] & ~sck_s[2];
  wire       sck_fall  = sel & ~sck_s[1] & sck_s[2];
  wire       frame_end = cs_s[1] & ~cs_s[2];
  wire       byte_done = sck_rise & (bit_cnt == 3'h7);
  wire [7:0] byte_in   = {in_sr[6:0], si_s[1]};
  wire       wp_low    = ~wp_s[1];

  assign status_register = {status_write_disable, quad_enable, block_protect,
                            write_enable_latch, busy_flag};

  // Address decode onto sectors and blocks.
  wire [`FSWG_ADDR_W-1:0] addr25 = addr_sr[`FSWG_ADDR_W-1:0];
  wire [`FSWG_ADDR_W-1:`FSWG_BLK64_LSB] blk64 = addr25[`FSWG_ADDR_W-1:`FSWG_BLK64_LSB];

  // Top-area protection: a setting n protects the top 2^(n-1) 64 KB blocks.
  // Settings of ten and above are capped at the whole array so the floor cannot wrap.
  wire [10:0] prot_count = (block_protect == 4'h0) ? 11'h000 :
                           (block_protect >= 4'ha) ? {1'b0, `FSWG_BLK64_COUNT} :
                           (11'h001 << (block_protect - 4'h1));
  wire [10:0] prot_floor = {1'b0, `FSWG_BLK64_COUNT} - prot_count;
  wire        addr_prot  = (prot_count != 11'h000) & ({2'b00, blk64} >= prot_floor);

  wire op_is_addr = (opcode == `FSWG_OP_PROG) | (opcode == `FSWG_OP_SECT) |
                    (opcode == `FSWG_OP_BLK32) | (opcode == `FSWG_OP_BLK64);
  wire sw_locked  = status_write_disable & wp_low;

  // Frame-end decisions; every write class needs the latch and an idle device.
  wire idle_latch   = ~busy_flag & write_enable_latch;
  wire do_set_latch = frame_end & ~busy_flag & (state != fswg_st_cmd) &
                      (opcode == `FSWG_SET_WRITE_LATCH_CMD);
  wire do_clr_latch = frame_end & ~busy_flag & (state != fswg_st_cmd) &
                      (opcode == `FSWG_CLEAR_WRITE_LATCH_CMD);
  wire do_status_wr = frame_end & idle_latch & (opcode == `FSWG_STATUS_WRITE_CMD) & wr_valid &
                      ~sw_locked;
  wire do_addr_op   = frame_end & idle_latch & op_is_addr & addr_done & ~addr_prot;
  wire do_chip      = frame_end & idle_latch & (opcode == `FSWG_OP_CHIP) &
                      (state != fswg_st_cmd) & (block_protect == 4'h0);
  wire do_start     = do_status_wr | do_addr_op | do_chip;
  wire susp_ok    = busy_flag & (busy_kind != fswg_kind_status) & (busy_kind != fswg_kind_none);

  fswg_kind_type start_kind;
  assign start_kind = (opcode == `FSWG_STATUS_WRITE_CMD) ? fswg_kind_status :
                      (opcode == `FSWG_OP_PROG)  ? fswg_kind_prog   :
                      (opcode == `FSWG_OP_SECT)  ? fswg_kind_sect   :
                      (opcode == `FSWG_OP_BLK32) ? fswg_kind_blk32  :
                      (opcode == `FSWG_OP_BLK64) ? fswg_kind_blk64  : fswg_kind_chip;

  // While busy, an opcode other than status read or suspend sends the frame to skip.
  wire cmd_ok_busy = (byte_in == `FSWG_STATUS_READ_CMD) |
                     (byte_in == `FSWG_OP_SUSPEND);
  wire byte_is_addr = (byte_in == `FSWG_OP_PROG) | (byte_in == `FSWG_OP_SECT) |
                      (byte_in == `FSWG_OP_BLK32) | (byte_in == `FSWG_OP_BLK64);

  always_comb begin
    next_state = state;
    case (state)
      fswg_st_cmd: begin
        if (byte_done) begin
          if (busy_flag && !cmd_ok_busy) begin
            next_state = fswg_st_skip;
          end else if (byte_is_addr) begin
            next_state = fswg_st_addr;
          end else if (byte_in == `FSWG_STATUS_READ_CMD || byte_in == `FSWG_STATUS_WRITE_CMD) begin
            next_state = fswg_st_data;
          end else begin
            next_state = fswg_st_skip;
          end
        end
      end
      fswg_st_addr: begin
        if (byte_done && addr_cnt == `FSWG_ADDR_BYTES - 3'h1) begin
          next_state = fswg_st_data;
        end
      end
      fswg_st_data: next_state = fswg_st_data;
      fswg_st_skip: next_state = fswg_st_skip;
      default:      next_state = fswg_st_cmd;
    endcase
    if (!sel) begin
      next_state = fswg_st_cmd;
    end
  end

  // Serial shift-in and frame decoding.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state     <= fswg_st_cmd;
      opcode    <= 8'h00;
      in_sr     <= 8'h00;
      bit_cnt   <= 3'h0;
      addr_cnt  <= 3'h0;
      addr_done <= 1'b0;
      addr_sr   <= 32'h0;
      wr_data   <= 8'h00;
      wr_valid  <= 1'b0;
    end else begin
      state <= next_state;
      if (!sel) begin
        bit_cnt <= 3'h0;
        if (frame_end) begin
          addr_cnt  <= 3'h0;
          addr_done <= 1'b0;
          wr_valid  <= 1'b0;
        end
      end else if (sck_rise) begin
        in_sr   <= byte_in;
        bit_cnt <= bit_cnt + 3'h1;
      end
      if (byte_done) begin
        if (state == fswg_st_cmd) begin
          opcode <= byte_in;
        end else if (state == fswg_st_addr) begin
          addr_sr  <= {addr_sr[23:0], byte_in};
          addr_cnt <= addr_cnt + 3'h1;
          if (addr_cnt == `FSWG_ADDR_BYTES - 3'h1) begin
            addr_done <= 1'b1;
          end
        end else if (state == fswg_st_data && opcode == `FSWG_STATUS_WRITE_CMD && !wr_valid) begin
          wr_data  <= byte_in;
          wr_valid <= 1'b1;
        end
      end
    end
  end

  // Status readout, re-sampled at each byte boundary so a polled busy bit stays live.
  wire out_bit = (out_cnt == 3'h0) ? status_register[7] : out_sr[7];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_active <= 1'b0;
      out_sr    <= 8'h00;
      out_cnt   <= 3'h0;
      so        <= 1'b0;
    end else if (!sel) begin
      rd_active <= 1'b0;
      out_cnt   <= 3'h0;
    end else begin
      if (byte_done && state == fswg_st_cmd && byte_in == `FSWG_STATUS_READ_CMD) begin
        rd_active <= 1'b1;
      end
      if (sck_fall && rd_active) begin
        so      <= out_bit;
        out_sr  <= (out_cnt == 3'h0) ? {status_register[6:0], 1'b0} : {out_sr[6:0], 1'b0};
        out_cnt <= out_cnt + 3'h1;
      end
    end
  end

  assign so_oe_n = ~(sel & rd_active);

  // Status bits, busy tracking and operation launch.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {status_write_disable, quad_enable, block_protect,
       write_enable_latch, busy_flag} <= `FSWG_STATUS_RESET;
      busy_kind            <= fswg_kind_none;
      op_start             <= 1'b0;
      op_kind              <= fswg_kind_none;
      op_addr              <= '0;
      op_sector            <= '0;
      op_blk32             <= '0;
      op_blk64             <= '0;
      suspend_req          <= 1'b0;
    end else begin
      op_start    <= do_start;
      suspend_req <= frame_end & (opcode == `FSWG_OP_SUSPEND) & susp_ok &
                     (state != fswg_st_cmd);
      if (do_set_latch) begin
        write_enable_latch <= 1'b1;
      end else if (do_clr_latch) begin
        write_enable_latch <= 1'b0;
      end else if (busy_flag && op_done) begin
        write_enable_latch <= 1'b0;
      end
      if (do_status_wr) begin
        block_protect        <= wr_data[`FSWG_BIT_BP_HI:`FSWG_BIT_BP_LO];
        quad_enable          <= wr_data[`FSWG_BIT_QUAD_ENABLE];
        status_write_disable <= wr_data[`FSWG_BIT_STATUS_WRITE_DISABLE];
      end
      if (do_start) begin
        busy_flag <= 1'b1;
        busy_kind <= start_kind;
        op_kind   <= start_kind;
        op_addr   <= addr25;
        op_sector <= addr25[`FSWG_ADDR_W-1:`FSWG_SECT_LSB];
        op_blk32  <= addr25[`FSWG_ADDR_W-1:`FSWG_BLK32_LSB];
        op_blk64  <= blk64;
      end else if (busy_flag && op_done) begin
        busy_flag <= 1'b0;
        busy_kind <= fswg_kind_none;
      end
    end
  end

endmodule : fswg_top

// ===== hdl/fswg_consts.svh
// Constants of the flash status and write-gating block.
// Assumes it is included by the top module and by the port checker only.
`ifndef FSWG_CONSTS_SVH
`define FSWG_CONSTS_SVH

`define FSWG_BIT_BUSY                  0
`define FSWG_BIT_WRITE_ENABLE_LATCH    1
`define FSWG_BIT_BP_LO                 2
`define FSWG_BIT_BP_HI                 5
`define FSWG_BIT_QUAD_ENABLE           6
`define FSWG_BIT_STATUS_WRITE_DISABLE  7
`define FSWG_STATUS_RESET              8'h00

`define FSWG_SET_WRITE_LATCH_CMD       8'h06
`define FSWG_CLEAR_WRITE_LATCH_CMD     8'h04
`define FSWG_STATUS_READ_CMD           8'h05
`define FSWG_STATUS_WRITE_CMD          8'h01
`define FSWG_OP_PROG      8'h02
`define FSWG_OP_SECT      8'h20
`define FSWG_OP_BLK32     8'h52
`define FSWG_OP_BLK64     8'hd8
`define FSWG_OP_CHIP      8'hc7
`define FSWG_OP_SUSPEND   8'h75

`define FSWG_ADDR_BYTES   3'h4
`define FSWG_ADDR_W       25
`define FSWG_SECT_LSB     12
`define FSWG_BLK32_LSB    15
`define FSWG_BLK64_LSB    16
`define FSWG_BLK64_COUNT  10'h200

`endif

// ===== hdl/fswg_pkg.sv
// Types shared by the flash status and write-gating block.
// Assumes the constants header sits beside it.
package fswg_pkg;
  typedef enum logic [1:0] {
    fswg_st_cmd  = 2'b00,
    fswg_st_addr = 2'b01,
    fswg_st_data = 2'b11,
    fswg_st_skip = 2'b10
  } fswg_state_type;

  typedef enum logic [2:0] {
    fswg_kind_none   = 3'h0,
    fswg_kind_status = 3'h1,
    fswg_kind_prog   = 3'h2,
    fswg_kind_sect   = 3'h3,
    fswg_kind_blk32  = 3'h4,
    fswg_kind_blk64  = 3'h5,
    fswg_kind_chip   = 3'h6
  } fswg_kind_type;
endpackage : fswg_pkg

// ===== sim/fswg_asserts.sv
// Port checker for the flash status and write-gating block.
// Assumes one clock domain with synchronous active-low reset; bound below.
`include "fswg_consts.svh"
module fswg_chk
  import fswg_pkg::*;
(
  input wire logic                                  clk,
  input wire logic                                  rst_n,
  input wire logic                                  cs_n,
  input wire logic                                  so_oe_n,
  input wire logic                                  op_done,
  input wire logic                                  op_start,
  input wire fswg_kind_type                         op_kind,
  input wire logic [`FSWG_ADDR_W-1:0]               op_addr,
  input wire logic [`FSWG_ADDR_W-1:`FSWG_SECT_LSB]  op_sector,
  input wire logic [`FSWG_ADDR_W-1:`FSWG_BLK32_LSB] op_blk32,
  input wire logic [`FSWG_ADDR_W-1:`FSWG_BLK64_LSB] op_blk64,
  input wire logic                                  suspend_req,
  input wire logic                                  quad_enable,
  input wire logic [7:0]                            status_register
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Six cycles leave room for the chip-select synchroniser.
  sequence s_idle; cs_n [*6]; endsequence
  sequence s_finish; status_register[0] && op_done; endsequence
  a_oe_idle: assert property (s_idle |-> so_oe_n)
    else $error("so driven while deselected");
  a_done_clear: assert property (s_finish |=> !status_register[0] && !status_register[1])
    else $error("completion left busy or latch set");
  a_busy_hold: assert property (status_register[0] && !op_done |=> status_register[0])
    else $error("busy dropped before completion");
  a_start_busy: assert property (op_start |-> status_register[0] && !$past(status_register[0]))
    else $error("start without fresh busy");
  a_start_pulse: assert property (op_start |=> !op_start)
    else $error("start longer than one cycle");
  a_latch_gate: assert property ($rose(status_register[0]) |-> $past(status_register[1]))
    else $error("operation began with latch clear");
  a_wsr_latch: assert property (op_start && op_kind == fswg_kind_status |-> status_register[1])
    else $error("status write changed the latch");
  a_suspend_busy: assert property (suspend_req |-> status_register[0] && $past(status_register[0]))
    else $error("suspend accepted while idle");
  // Non-volatile bits may only move on the cycle a status write launches.
  a_nv_write: assert property ($changed(status_register[7:2]) || $changed(quad_enable) |->
    op_start && op_kind == fswg_kind_status)
    else $error("non-volatile status bits changed without a status write");
  a_index_map: assert property (op_start |-> op_sector == op_addr[24:12] && op_blk32 == op_addr[24:15]
    && op_blk64 == op_addr[24:16])
    else $error("sector or block index wrong");
endmodule : fswg_chk

bind fswg_top fswg_chk u_chk (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .so_oe_n(so_oe_n),
  .op_done(op_done), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
  .op_sector(op_sector), .op_blk32(op_blk32), .op_blk64(op_blk64), .suspend_req(suspend_req),
  .quad_enable(quad_enable), .status_register(status_register));

// ===== sim/fswg_host_model.sv
// Serial host controller that sends mode 0 frames to the flash block.
// Assumes clk at 100 MHz; the serial clock runs at 80 ns only inside frames.
module fswg_host_model (
  input  wire logic clk,
  input  wire logic so,
  output logic      sck,
  output logic      cs_n,
  output logic      si
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Bits go out MSB first; so is taken just before each fall, well after it settled.
  task automatic frame(input logic [47:0] d, input int n, output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    cs_n <= 1'b0;
    for (i = 0; i < 8 * n; i++) begin
      si <= d[47 - i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      rx = {rx[14:0], so};
      sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (6) @(posedge clk);
  endtask : frame
endmodule : fswg_host_model

// ===== sim/testbench.sv
// Self-checking bench for the flash status and write-gating block.
// Assumes the host model drives the serial pins and this bench plays the array engine.
module testbench import fswg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [47:0] d;
    logic [2:0]  n;
    logic        dn;
    logic [7:0]  e;
    logic [2:0]  k;
  } fswg_tb_row_type;
  localparam fswg_tb_row_type rows [22] = '{
    '{48'h0500_0000_0000, 3'h3, 1'b0, 8'h00, 3'h0},
    '{48'h01fc_0000_0000, 3'h2, 1'b0, 8'h00, 3'h0},
    '{48'h0600_0000_0000, 3'h1, 1'b0, 8'h02, 3'h0},
    '{48'h0400_0000_0000, 3'h1, 1'b0, 8'h00, 3'h0},
    '{48'h0600_0000_0000, 3'h1, 1'b0, 8'h02, 3'h0},
    '{48'h017f_0000_0000, 3'h2, 1'b0, 8'h7f, 3'h1},
    '{48'h0500_0000_0000, 3'h3, 1'b0, 8'h7f, 3'h0},
    '{48'h0400_0000_0000, 3'h1, 1'b0, 8'h7f, 3'h0},
    '{48'h0000_0000_0000, 3'h0, 1'b1, 8'h7c, 3'h0},
    '{48'h0600_0000_0000, 3'h1, 1'b0, 8'h7e, 3'h0},
    '{48'h0201_2345_6700, 3'h5, 1'b0, 8'h7e, 3'h0},
    '{48'h0100_0000_0000, 3'h2, 1'b1, 8'h00, 3'h1},
    '{48'h0600_0000_0000, 3'h1, 1'b0, 8'h02, 3'h0},
    '{48'h2000_0100_0000, 3'h5, 1'b1, 8'h00, 3'h3},
    '{48'h0600_0000_0000, 3'h1, 1'b0, 8'h02, 3'h0},
    '{48'h5200_0100_0000, 3'h5, 1'b1, 8'h00, 3'h4},
    '{48'h0600_0000_0000, 3'h1, 1'b0, 8'h02, 3'h0},
    '{48'hd800_0100_0000, 3'h5, 1'b1, 8'h00, 3'h5},
    '{48'h0600_0000_0000, 3'h1, 1'b0, 8'h02, 3'h0},
    '{48'hc700_0000_0000, 3'h1, 1'b1, 8'h00, 3'h6},
    '{48'h0600_0000_0000, 3'h1, 1'b0, 8'h02, 3'h0},
    '{48'h0180_0000_0000, 3'h2, 1'b1, 8'h80, 3'h1}};
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          wp_n = 1'b1;
  logic          op_done = 1'b0;
  logic          sus_seen = 1'b0;
  logic [2:0]    kind_seen;
  int            start_count = 0;
  wire logic     so_line;
  logic [24:0]   addr_seen;
  wire logic     sck, cs_n, si, so, so_oe_n, op_start, suspend_req, quad_enable;
  fswg_kind_type op_kind;
  logic [24:0]   op_addr;
  logic [24:12]  op_sector;
  logic [24:15]  op_blk32;
  logic [24:16]  op_blk64;
  logic [7:0]    status_register;
  int            fail_count = 0;
  int            checks = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (op_start) begin
      kind_seen   <= op_kind;
      addr_seen   <= op_addr;
      start_count <= start_count + 1;
    end
    if (suspend_req) sus_seen <= 1'b1;
  end
  // A released data line reads as the inverse, so a sample taken while undriven shows up.
  assign so_line = so_oe_n ? ~so : so;
  fswg_host_model host (.clk(clk), .so(so_line), .sck(sck), .cs_n(cs_n), .si(si));
  fswg_top uut (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .so(so), .so_oe_n(so_oe_n), .op_done(op_done), .op_start(op_start), .op_kind(op_kind),
    .op_addr(op_addr), .op_sector(op_sector), .op_blk32(op_blk32), .op_blk64(op_blk64),
    .suspend_req(suspend_req), .quad_enable(quad_enable), .status_register(status_register));
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  // An optional frame, an optional completion pulse from the array engine, then the checks.
  task step(input logic [47:0] d, input int n, input logic dn, input logic [7:0] e,
            input logic [2:0] k);
    logic [15:0] rx;
    int          starts_before;
    starts_before = start_count;
    if (n > 0) host.frame(d, n, rx);
    repeat (8) @(posedge clk);
    if (dn) begin
      op_done <= 1'b1;
      @(posedge clk);
      op_done <= 1'b0;
      repeat (3) @(posedge clk);
    end
    if (n == 3 && d[47:40] == 8'h05) check("status_read", rx, {e, e});
    else check("status_register", status_register, e);
    check("op_kind", (start_count == starts_before) ? 3'h0 : kind_seen, k);
    check("op_starts", start_count - starts_before, (k != 3'h0) ? 1 : 0);
  endtask : step
  task report_and_stop;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #300_000;
    fail_count++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("status_after_reset", status_register, 8'h00);
    for (int i = 0; i < 22; i++) begin
      step(rows[i].d, rows[i].n, rows[i].dn, rows[i].e, rows[i].k);
      $display("row %0d done", i);
    end
    wp_n <= 1'b0;
    step(48'h0600_0000_0000, 1, 1'b0, 8'h82, 3'h0);
    step(48'h0104_0000_0000, 2, 1'b0, 8'h82, 3'h0);
    wp_n <= 1'b1;
    step(48'h0104_0000_0000, 2, 1'b1, 8'h04, 3'h1);
    check("quad_enable", quad_enable, 1'b0);
    step(48'h0600_0000_0000, 1, 1'b0, 8'h06, 3'h0);
    step(48'h0201_ff00_0000, 5, 1'b0, 8'h06, 3'h0);
    step(48'h0201_fef1_2300, 5, 1'b0, 8'h07, 3'h2);
    check("op_addr", addr_seen, 25'h1fef123);
    check("op_sector", op_sector, 13'h1fef);
    check("op_blk32", op_blk32, 10'h3fd);
    check("op_blk64", op_blk64, 9'h1fe);
    check("suspend_idle", sus_seen, 1'b0);
    step(48'h7500_0000_0000, 1, 1'b1, 8'h04, 3'h0);
    check("suspend_req", sus_seen, 1'b1);
    step(48'h0600_0000_0000, 1, 1'b0, 8'h06, 3'h0);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("status_after_reset", status_register, 8'h00);
    $display("hand tests done");
    report_and_stop;
  end
endmodule : testbench
